// ===== verilog/fws_map.vh
`ifndef FWS_MAP_VH
`define FWS_MAP_VH
// Software register byte addresses.
`define FWS_REG_CTRL     8'h00
`define FWS_REG_ADDR     8'h04
`define FWS_REG_DATA     8'h08
`define FWS_REG_STAT     8'h0c
`define FWS_REG_RDATA    8'h10
// Command codes written to the control register.
`define FWS_CMD_READ     3'h1
`define FWS_CMD_PROG     3'h2
`define FWS_CMD_SERASE   3'h3
`define FWS_CMD_CERASE   3'h4
`define FWS_CMD_SUSPEND  3'h5
`define FWS_CMD_RESUME   3'h6
`define FWS_CMD_RESET    3'h7
// Flash status bit positions on the data bus.
`define FWS_BIT_POLL     7
`define FWS_BIT_TOG1     6
`define FWS_BIT_FAIL     5
`define FWS_BIT_WIN      3
`define FWS_BIT_TOG2     2
// Status register fields.
`define FWS_ST_BUSY      0
`define FWS_ST_DONE      1
`define FWS_ST_FAIL      2
`define FWS_ST_REJECT    3
`define FWS_ST_PINBUSY   4
// Bus cycle timing: 90 ns access, 4 ns clock, rounded up.
`define FWS_T_ACC_NS     90
`define FWS_CLK_NS       4
`define FWS_ACC_CYC      ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Output enable hold for toggle and polling reads: 10 ns.
`define FWS_T_OEH_NS     10
`define FWS_OEH_CYC      ((`FWS_T_OEH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Bus reset value of the control register.
`define FWS_CTRL_RST     8'h00
`endif

// ===== verilog/fws_bus_cycle.v
`timescale 1ns/1ps
`default_nettype none
`include "fws_map.vh"
// Runs one asynchronous flash read or write cycle on the pins.
module fws_bus_cycle
(
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire        start_i,
   input  wire        wr_i,
   input  wire [19:0] addr_i,
   input  wire [7:0]  wdata_i,
   input  wire [7:0]  dq_sync_i,
   output reg         done_o,
   output reg  [7:0]  rdata_o,
   output reg  [19:0] fl_addr_o,
   output reg  [7:0]  fl_dq_o,
   output reg         fl_dq_oe_o,
   output reg         fl_ce_n_o,
   output reg         fl_oe_n_o,
   output reg         fl_we_n_o
);
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_ACT  = 3'b010;
   localparam [2:0] S_HOLD = 3'b100;
   // Two extra cycles cover the input synchroniser latency on reads.
   localparam integer ACC_I  = `FWS_ACC_CYC + 2;
   localparam integer HOLD_I = `FWS_OEH_CYC;
   localparam [7:0]   ACC_N  = ACC_I[7:0];
   localparam [7:0]   HOLD_N = HOLD_I[7:0];
   reg [2:0] st_r;
   reg [7:0] cnt_r;
   reg       wr_r;
   always @(posedge clk_sys_i)
   begin
      done_o <= 1'b0;
      if (rst_i)
      begin
         st_r       <= S_IDLE;
         cnt_r      <= 8'h00;
         wr_r       <= 1'b0;
         rdata_o    <= 8'h00;
         fl_addr_o  <= 20'h00000;
         fl_dq_o    <= 8'h00;
         fl_dq_oe_o <= 1'b0;
         fl_ce_n_o  <= 1'b1;
         fl_oe_n_o  <= 1'b1;
         fl_we_n_o  <= 1'b1;
      end
      else
      begin
         case (st_r)
            S_IDLE:
            begin
               if (start_i)
               begin
                  st_r       <= S_ACT;
                  cnt_r      <= ACC_N;
                  wr_r       <= wr_i;
                  fl_addr_o  <= addr_i;
                  fl_dq_o    <= wdata_i;
                  fl_dq_oe_o <= wr_i;
                  fl_ce_n_o  <= 1'b0;
                  fl_oe_n_o  <= wr_i;
                  fl_we_n_o  <= ~wr_i;
               end
            end
            S_ACT:
            begin
               if (cnt_r == 8'h00)
               begin
                  if (!wr_r)
                     rdata_o <= dq_sync_i;
                  st_r      <= S_HOLD;
                  cnt_r     <= HOLD_N;
                  fl_ce_n_o <= 1'b1;
                  fl_oe_n_o <= 1'b1;
                  fl_we_n_o <= 1'b1;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            S_HOLD:
            begin
               // Each read is a separate chip enable cycle so toggle bits advance.
               if (cnt_r == 8'h00)
               begin
                  st_r       <= S_IDLE;
                  fl_dq_oe_o <= 1'b0;
                  done_o     <= 1'b1;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            end
            default:
               st_r <= S_IDLE;
         endcase
      end
   end
endmodule // fws_bus_cycle
`default_nettype wire

// ===== verilog/fws_ctrl.v
// Contract
// - After fail, host writes reset command.
// - Check window flag before and after additions.
// - Confirm acceptance by polling, then window; the code uses the toggle bit instead.
// - Read status twice to judge toggling.
// - On fail flag, recheck toggle bit.
// - Status reads use monitored operation address.
`timescale 1ns/1ps
`default_nettype none
`include "fws_map.vh"
module fws_ctrl
(
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   input  wire [7:0]  fl_dq_i,
   input  wire        fl_busy_n_i,
   output wire [19:0] fl_addr_o,
   output wire [7:0]  fl_dq_o,
   output wire        fl_dq_oe_o,
   output wire        fl_ce_n_o,
   output wire        fl_oe_n_o,
   output wire        fl_we_n_o
);
   localparam [6:0] S_IDLE  = 7'b0000001;
   localparam [6:0] S_SEQ   = 7'b0000010;
   localparam [6:0] S_RD1   = 7'b0000100;
   localparam [6:0] S_RD2   = 7'b0001000;
   localparam [6:0] S_JUDGE = 7'b0010000;
   localparam [6:0] S_WIN   = 7'b0100000;
   localparam [6:0] S_WAIT  = 7'b1000000;

   reg [6:0]  st_r;
   reg [2:0]  cmd_r;
   reg [19:0] addr_r;
   reg [7:0]  data_r;
   reg [7:0]  rdata_r;
   reg        busy_r;
   reg        done_r;
   reg        fail_r;
   reg        reject_r;
   reg        win_before_r;
   reg        fail_seen_r;
   reg [2:0]  step_r;
   reg [2:0]  nsteps_r;
   reg [7:0]  first_r;
   reg [7:0]  dq_s1_r;
   reg [7:0]  dq_s2_r;
   reg        bz_s1_r;
   reg        bz_s2_r;
   reg        cyc_start_r;
   reg        cyc_wr_r;
   reg [19:0] cyc_addr_r;
   reg [7:0]  cyc_data_r;
   wire       cyc_done;
   wire [7:0] cyc_rdata;

   // Unlock write sequence step: returns {address, data}.
   function [27:0] seq_word;
      input [2:0]  cmd;
      input [2:0]  step;
      input [19:0] addr;
      input [7:0]  data;
      begin
         seq_word = {20'h00555, 8'haa};
         case (step)
            3'h0: seq_word = {20'h00555, 8'haa};
            3'h1: seq_word = {20'h002aa, 8'h55};
            3'h2: seq_word = (cmd == `FWS_CMD_PROG) ? {20'h00555, 8'ha0} : {20'h00555, 8'h80};
            3'h3: seq_word = (cmd == `FWS_CMD_PROG) ? {addr, data} : {20'h00555, 8'haa};
            3'h4: seq_word = {20'h002aa, 8'h55};
            default: seq_word = (cmd == `FWS_CMD_SERASE) ? {addr, 8'h30} : {20'h00555, 8'h10};
         endcase
         if (cmd == `FWS_CMD_SUSPEND)
            seq_word = {addr, 8'hb0};
         if (cmd == `FWS_CMD_RESUME)
            seq_word = {addr, 8'h30};
         if (cmd == `FWS_CMD_RESET)
            seq_word = {addr, 8'hf0};
      end
   endfunction

   wire [27:0] cur_word = seq_word(cmd_r, step_r, addr_r, data_r);
   wire        tog1_moves = first_r[`FWS_BIT_TOG1] ^ cyc_rdata[`FWS_BIT_TOG1];
   wire [27:0] nxt_word = seq_word(cmd_r, step_r + 3'h1, addr_r, data_r);

   fws_bus_cycle u_cyc
   (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .start_i    (cyc_start_r),
      .wr_i       (cyc_wr_r),
      .addr_i     (cyc_addr_r),
      .wdata_i    (cyc_data_r),
      .dq_sync_i  (dq_s2_r),
      .done_o     (cyc_done),
      .rdata_o    (cyc_rdata),
      .fl_addr_o  (fl_addr_o),
      .fl_dq_o    (fl_dq_o),
      .fl_dq_oe_o (fl_dq_oe_o),
      .fl_ce_n_o  (fl_ce_n_o),
      .fl_oe_n_o  (fl_oe_n_o),
      .fl_we_n_o  (fl_we_n_o)
   );

   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
         bz_s1_r <= 1'b1;
         bz_s2_r <= 1'b1;
      end
      else
      begin
         dq_s1_r <= fl_dq_i;
         dq_s2_r <= dq_s1_r;
         bz_s1_r <= fl_busy_n_i;
         bz_s2_r <= bz_s1_r;
      end
   end

   always @(posedge clk_sys_i)
   begin
      cyc_start_r <= 1'b0;
      if (rst_i)
      begin
         st_r         <= S_IDLE;
         cmd_r        <= 3'h0;
         addr_r       <= 20'h00000;
         data_r       <= 8'h00;
         rdata_r      <= 8'h00;
         busy_r       <= 1'b0;
         done_r       <= 1'b0;
         fail_r       <= 1'b0;
         reject_r     <= 1'b0;
         win_before_r <= 1'b0;
         fail_seen_r  <= 1'b0;
         step_r       <= 3'h0;
         nsteps_r     <= 3'h0;
         first_r      <= 8'h00;
         cyc_wr_r     <= 1'b0;
         cyc_addr_r   <= 20'h00000;
         cyc_data_r   <= 8'h00;
         reg_rdata_o  <= 32'h00000000;
      end
      else
      begin
         reg_rdata_o <= 32'h00000000;
         if (reg_rd_i)
         begin
            if (reg_addr_i == `FWS_REG_CTRL)
               reg_rdata_o <= {29'h0, cmd_r};
            else if (reg_addr_i == `FWS_REG_ADDR)
               reg_rdata_o <= {12'h000, addr_r};
            else if (reg_addr_i == `FWS_REG_DATA)
               reg_rdata_o <= {24'h000000, data_r};
            else if (reg_addr_i == `FWS_REG_STAT)
               reg_rdata_o <= {27'h0, ~bz_s2_r, reject_r, fail_r, done_r, busy_r};
            else if (reg_addr_i == `FWS_REG_RDATA)
               reg_rdata_o <= {24'h000000, rdata_r};
         end
         if (reg_wr_i && !busy_r)
         begin
            if (reg_addr_i == `FWS_REG_ADDR)
               addr_r <= reg_wdata_i[19:0];
            else if (reg_addr_i == `FWS_REG_DATA)
               data_r <= reg_wdata_i[7:0];
            else if (reg_addr_i == `FWS_REG_CTRL && reg_wdata_i[2:0] != 3'h0)
            begin
               cmd_r    <= reg_wdata_i[2:0];
               busy_r   <= 1'b1;
               done_r   <= 1'b0;
               step_r   <= 3'h0;
               fail_seen_r <= 1'b0;
               if (reg_wdata_i[2:0] == `FWS_CMD_RESET)
                  fail_r <= 1'b0;
               case (reg_wdata_i[2:0])
                  `FWS_CMD_PROG:   nsteps_r <= 3'h3;
                  `FWS_CMD_SERASE: nsteps_r <= 3'h5;
                  `FWS_CMD_CERASE: nsteps_r <= 3'h5;
                  default:         nsteps_r <= 3'h0;
               endcase
               // Adding a sector: sample the window flag first, never skip it.
               if (reg_wdata_i[2:0] == `FWS_CMD_SERASE && cmd_r == `FWS_CMD_SERASE &&
                   !done_r)
                  st_r <= S_WIN;
               else if (reg_wdata_i[2:0] == `FWS_CMD_READ)
                  st_r <= S_WAIT;
               else
                  st_r <= S_SEQ;
               win_before_r <= 1'b0;
               reject_r <= 1'b0;
               cyc_wr_r    <= 1'b0;
               cyc_addr_r  <= addr_r;
               // Only a plain read or the window pre-check opens with a bus read here.
               // A command sequence must start with its first unlock write instead.
               if (reg_wdata_i[2:0] == `FWS_CMD_READ || (reg_wdata_i[2:0] == `FWS_CMD_SERASE &&
                   cmd_r == `FWS_CMD_SERASE && !done_r))
                  cyc_start_r <= 1'b1;
            end
         end
         case (st_r)
            S_IDLE: ;
            S_WAIT:
            begin
               // Plain array read only; the window pre-check result is handled in S_WIN.
               if (cyc_done)
               begin
                  rdata_r <= cyc_rdata;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
                  st_r    <= S_IDLE;
               end
            end
            S_WIN:
            begin
               if (cyc_done)
               begin
                  win_before_r <= cyc_rdata[`FWS_BIT_WIN];
                  if (cyc_rdata[`FWS_BIT_WIN])
                  begin
                     // Window already closed: more sectors would be ignored.
                     reject_r <= 1'b1;
                     busy_r   <= 1'b0;
                     st_r     <= S_IDLE;
                  end
                  else
                  begin
                     // Open window: only the final sector address write (step 5, data 0x30) is needed.
                     step_r      <= 3'h5;
                     st_r        <= S_SEQ;
                     cyc_start_r <= 1'b1;
                     cyc_wr_r    <= 1'b1;
                     cyc_addr_r  <= addr_r;
                     cyc_data_r  <= 8'h30;
                  end
               end
            end
            S_SEQ:
            begin
               if (cyc_start_r == 1'b0 && cyc_done == 1'b0 && step_r == 3'h0 &&
                   fl_ce_n_o && !cyc_wr_r)
               begin
                  cyc_start_r <= 1'b1;
                  cyc_wr_r    <= 1'b1;
                  cyc_addr_r  <= cur_word[27:8];
                  cyc_data_r  <= cur_word[7:0];
               end
               else if (cyc_done)
               begin
                  if (step_r >= nsteps_r)
                  begin
                     // Status reads stay at the monitored address.
                     st_r        <= S_RD1;
                     cyc_start_r <= 1'b1;
                     cyc_wr_r    <= 1'b0;
                     cyc_addr_r  <= addr_r;
                  end
                  else
                  begin
                     step_r      <= step_r + 3'h1;
                     cyc_start_r <= 1'b1;
                     cyc_wr_r    <= 1'b1;
                     cyc_addr_r  <= nxt_word[27:8];
                     cyc_data_r  <= nxt_word[7:0];
                  end
               end
            end
            S_RD1:
            begin
               if (cyc_done)
               begin
                  first_r     <= cyc_rdata;
                  st_r        <= S_RD2;
                  cyc_start_r <= 1'b1;
               end
            end
            S_RD2:
            begin
               if (cyc_done)
                  st_r <= S_JUDGE;
            end
            S_JUDGE:
            begin
               // Two successive reads decide toggling.
               if (!tog1_moves)
               begin
                  rdata_r <= cyc_rdata;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
                  // A sector erase whose window pre-check saw the closed window was rejected.
                  if (cmd_r == `FWS_CMD_SERASE && win_before_r)
                     reject_r <= 1'b1;
                  st_r    <= S_IDLE;
               end
               else if (fail_seen_r)
               begin
                  // Still toggling after the fail flag: the operation failed.
                  fail_r <= 1'b1;
                  busy_r <= 1'b0;
                  st_r   <= S_IDLE;
               end
               else
               begin
                  // Fail flag seen: read the toggle bit again before judging.
                  if (cyc_rdata[`FWS_BIT_FAIL])
                     fail_seen_r <= 1'b1;
                  if (cmd_r == `FWS_CMD_SERASE && !cyc_rdata[`FWS_BIT_WIN] && step_r == 3'h5)
                  begin
                     // Acceptance shown by toggling, window still open: return.
                     busy_r <= 1'b0;
                     st_r   <= S_IDLE;
                  end
                  else
                  begin
                     st_r        <= S_RD1;
                     cyc_start_r <= 1'b1;
                     cyc_wr_r    <= 1'b0;
                  end
               end
            end
            default:
               st_r <= S_IDLE;
         endcase
      end
   end
endmodule // fws_ctrl
`default_nettype wire

// ===== testbench/fws_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "fws_map.vh"
module fws_ctrl_monitor
(
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [19:0] fl_addr_o,
   input wire logic [7:0]  fl_dq_o,
   input wire logic        fl_dq_oe_o,
   input wire logic        fl_ce_n_o,
   input wire logic        fl_oe_n_o,
   input wire logic        fl_we_n_o
);
   // Shadow of the address register, so every flash read can be tied to the operation address.
   logic [19:0] addr_r;
   always_ff @(posedge clk_sys_i)
      if (rst_i)
         addr_r <= 20'h00000;
      else if (reg_wr_i && reg_addr_i == `FWS_REG_ADDR)
         addr_r <= reg_wdata_i[19:0];
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_we_low;
      (!fl_we_n_o) [*7];
   endsequence
   sequence s_rd_slot;
      reg_rd_i && reg_addr_i == 8'h14;
   endsequence
   AST_RDATA_IDLE:
      assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not zero outside its slot");
   AST_UNMAPPED:
      assert property (s_rd_slot |=> reg_rdata_o == 32'h0)
      else $error("unmapped read returned data");
   AST_NO_FIGHT:
      assert property (!fl_oe_n_o |-> !fl_dq_oe_o)
      else $error("data bus driven during a flash read");
   AST_STROBE_EXCL:
      assert property (!(!fl_oe_n_o && !fl_we_n_o))
      else $error("read and write strobes low together");
   AST_CE_COVERS:
      assert property ((!fl_oe_n_o || !fl_we_n_o) |-> !fl_ce_n_o)
      else $error("strobe without chip enable");
   AST_WE_WIDTH:
      assert property ($fell(fl_we_n_o) |-> s_we_low)
      else $error("write pulse too short");
   AST_WE_HOLD:
      assert property (!fl_we_n_o && !$past(fl_we_n_o) |-> $stable(fl_dq_o) && $stable(fl_addr_o))
      else $error("address or data moved during write pulse");
   AST_WE_DRIVE:
      assert property (!fl_we_n_o |-> fl_dq_oe_o)
      else $error("write pulse without driven data");
   AST_READ_ADDR:
      assert property ($fell(fl_oe_n_o) |-> fl_addr_o == addr_r)
      else $error("flash read away from operation address");
endmodule // fws_ctrl_monitor
bind fws_ctrl fws_ctrl_monitor i_mon
(
   .clk_sys_i   (clk_sys_i),
   .rst_i       (rst_i),
   .reg_addr_i  (reg_addr_i),
   .reg_wdata_i (reg_wdata_i),
   .reg_wr_i    (reg_wr_i),
   .reg_rd_i    (reg_rd_i),
   .reg_rdata_o (reg_rdata_o),
   .fl_addr_o   (fl_addr_o),
   .fl_dq_o     (fl_dq_o),
   .fl_dq_oe_o  (fl_dq_oe_o),
   .fl_ce_n_o   (fl_ce_n_o),
   .fl_oe_n_o   (fl_oe_n_o),
   .fl_we_n_o   (fl_we_n_o)
);
`default_nettype wire

// ===== testbench/fws_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash; times are shortened so a run stays brief.
module fws_flash_model
#(
   parameter integer PROG_NS  = 1000,
   parameter integer LIMIT_NS = 2000,
   parameter integer WIN_NS   = 3000,
   parameter integer ERASE_NS = 4000
)
(
   input  wire logic [19:0] fl_addr_i,
   input  wire logic [7:0]  fl_dq_i,
   input  wire logic        fl_ce_n_i,
   input  wire logic        fl_oe_n_i,
   input  wire logic        fl_we_n_i,
   output wire logic [7:0]  fl_dq_o,
   output wire logic        fl_busy_n_o
);
   localparam logic [2:0] M_IDLE = 3'h0, M_PROG = 3'h1, M_FAIL = 3'h2, M_WIN = 3'h3;
   localparam logic [2:0] M_SUSP = 3'h5;
   logic [2:0]  mode = M_IDLE;
   logic [7:0]  mem [0:15];
   logic [23:0] hist = 24'h0;
   logic [15:0] sel = 16'h0;
   logic [7:0]  pd = 8'h0, last = 8'h0, rd_val, d;
   logic        t1 = 1'b0, t2 = 1'b0, bad = 1'b0, t2s;
   logic        wr_pend = 1'b0;
   longint      t_end = 0;
   initial
      for (int i = 0; i < 16; i++)
         mem[i] = 8'hff;
   assign t2s = t2 & sel[fl_addr_i[19:16]];
   always @*
      case (mode)
         M_IDLE: rd_val = mem[fl_addr_i[3:0]];
         M_PROG: rd_val = {~pd[7], t1, 6'h00};
         M_FAIL: rd_val = {~pd[7], t1, 6'h20};
         M_WIN: rd_val = {1'b0, t1, 3'h0, t2s, 2'h0};
         M_SUSP: rd_val = sel[fl_addr_i[19:16]] ? {2'h2, 3'h0, t2s, 2'h0}
                                                : mem[fl_addr_i[3:0]];
         default: rd_val = {1'b0, t1, 2'h0, 1'b1, t2s, 2'h0};
      endcase
   // A released bus shows the inverse of its last value, never a stale match.
   assign fl_dq_o = (!fl_ce_n_i && !fl_oe_n_i) ? rd_val : ~last;
   assign fl_busy_n_o = (mode == M_IDLE || mode == M_SUSP);
   always @(posedge fl_oe_n_i)
      last <= rd_val;
   always @(negedge fl_oe_n_i)
      if (!fl_ce_n_i)
      begin
         t1 <= ~t1;
         t2 <= ~t2;
      end
   // A write ends on whichever strobe rises first, and both may rise in one time step.
   always @(negedge fl_we_n_i or negedge fl_ce_n_i)
      wr_pend = !fl_we_n_i && !fl_ce_n_i;
   always @(posedge fl_we_n_i or posedge fl_ce_n_i)
      if (wr_pend)
      begin
         wr_pend = 1'b0;
         d = fl_dq_i;
         if (d == 8'hf0 && mode != 3'h4)
            mode = M_IDLE;
         else if (d == 8'hb0 && mode == 3'h4)
            mode = M_SUSP;
         else if (d == 8'h30 && mode == M_SUSP)
         begin
            mode = 3'h4;
            t_end = $time + ERASE_NS;
         end
         else if (mode == M_IDLE && hist == 24'haa55a0)
         begin
            pd = d;
            bad = |(d & ~mem[fl_addr_i[3:0]]);
            if (!bad)
               mem[fl_addr_i[3:0]] = mem[fl_addr_i[3:0]] & d;
            mode = M_PROG;
            t_end = $time + (bad ? LIMIT_NS : PROG_NS);
         end
         else if (mode == M_IDLE && hist == 24'h80aa55 && d == 8'h10)
         begin
            sel = 16'hffff;
            mode = 3'h4;
            t_end = $time + ERASE_NS;
         end
         else if ((mode == M_WIN || mode == M_IDLE && hist == 24'h80aa55) && d == 8'h30)
         begin
            sel[fl_addr_i[19:16]] = 1'b1;
            mode = M_WIN;
            t_end = $time + WIN_NS;
         end
         hist = {hist[15:0], d};
      end
   always #4
      if (mode != M_IDLE && mode != M_FAIL && mode != M_SUSP && $time >= t_end)
      begin
         if (mode == M_WIN)
         begin
            mode = 3'h4;
            t_end = $time + ERASE_NS;
         end
         else if (mode == M_PROG && bad)
            mode = M_FAIL;
         else
         begin
            if (mode == 3'h4)
               for (int i = 0; i < 16; i++)
                  mem[i] = 8'hff;
            sel = 16'h0;
            mode = M_IDLE;
         end
      end
endmodule // fws_flash_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fws_map.vh"
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic        rd_d      = 1'b0;
   logic [31:0] last_rd   = 32'h0;
   logic [31:0] rnd;
   logic [7:0]  pd;
   logic [63:0] exp_q [$];
   int          err_total = 0;
   int          compares  = 0;
   integer      seed      = 32'h71f1f4ab;
   wire  [31:0] reg_rdata;
   wire  [19:0] fl_addr;
   wire  [7:0]  dq_out, dq_in;
   wire         dq_oe, ce_n, oe_n, we_n, busy_n;
   initial forever #2 clk_sys_i = ~clk_sys_i;
   fws_ctrl i_dut
   (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .fl_dq_i(dq_in),
      .fl_busy_n_i(busy_n), .fl_addr_o(fl_addr), .fl_dq_o(dq_out), .fl_dq_oe_o(dq_oe),
      .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n)
   );
   fws_flash_model i_flash
   (
      .fl_addr_i(fl_addr), .fl_dq_i(dq_out), .fl_ce_n_i(ce_n), .fl_oe_n_i(oe_n),
      .fl_we_n_i(we_n), .fl_dq_o(dq_in), .fl_busy_n_o(busy_n)
   );
   task automatic check(input logic [31:0] got, input logic [63:0] e);
      if (e[31:0] != 32'h0)
      begin
         compares++;
         if ((got & e[31:0]) !== e[63:32])
         begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e[63:32]);
         end
      end
   endtask
   // Each read result is matched against the oldest expectation noted by the driver.
   always @(posedge clk_sys_i)
   begin
      rd_d <= reg_rd;
      if (rd_d)
      begin
         last_rd = reg_rdata;
         check(reg_rdata, exp_q.pop_front());
      end
   end
   task automatic print_verdict;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back({e & m, m});
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
   endtask
   // Polls the busy flag; a hung controller ends the run instead of stalling it.
   task automatic wait_idle;
      int n;
      n = 0;
      last_rd = 32'h1;
      while (last_rd[`FWS_ST_BUSY] !== 1'b0 && n < 3000)
      begin
         bus_rd(`FWS_REG_STAT, 32'h0, 32'h0);
         repeat (2) @(posedge clk_sys_i);
         n++;
      end
      if (n >= 3000)
      begin
         err_total++;
         print_verdict;
      end
   endtask
   task automatic do_cmd(input logic [2:0] c, input logic [19:0] a, input logic [7:0] d);
      bus_wr(`FWS_REG_ADDR, {12'h0, a});
      bus_wr(`FWS_REG_DATA, {24'h0, d});
      bus_wr(`FWS_REG_CTRL, {29'h0, c});
      wait_idle;
   endtask
   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      bus_rd(`FWS_REG_CTRL, {24'h0, `FWS_CTRL_RST}, 32'hff);
      bus_rd(8'h14, 32'h0, 32'hffffffff);
      rnd = $random(seed);
      pd = rnd[7:0] & 8'h7f;
      do_cmd(`FWS_CMD_PROG, 20'h00013, pd);
      bus_rd(`FWS_REG_STAT, 32'h2, 32'h1e);
      do_cmd(`FWS_CMD_READ, 20'h00013, 8'h00);
      bus_rd(`FWS_REG_RDATA, {24'h0, pd}, 32'hff);
      do_cmd(`FWS_CMD_PROG, 20'h00013, 8'h80);
      bus_rd(`FWS_REG_STAT, 32'h4, 32'h4);
      do_cmd(`FWS_CMD_RESET, 20'h00000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h0, 32'h4);
      do_cmd(`FWS_CMD_READ, 20'h00013, 8'h00);
      bus_rd(`FWS_REG_RDATA, {24'h0, pd}, 32'hff);
      do_cmd(`FWS_CMD_SERASE, 20'h20000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h0, 32'h8);
      do_cmd(`FWS_CMD_SERASE, 20'h30000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h0, 32'h8);
      repeat (1000) @(posedge clk_sys_i);
      do_cmd(`FWS_CMD_SERASE, 20'h40000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h8, 32'h8);
      repeat (1200) @(posedge clk_sys_i);
      do_cmd(`FWS_CMD_READ, 20'h00013, 8'h00);
      bus_rd(`FWS_REG_RDATA, 32'hff, 32'hff);
      // Let the window close so the erase runs, then suspend and resume it.
      do_cmd(`FWS_CMD_SERASE, 20'h50000, 8'h00);
      repeat (800) @(posedge clk_sys_i);
      bus_rd(`FWS_REG_STAT, 32'h10, 32'h10);
      do_cmd(`FWS_CMD_SUSPEND, 20'h50000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h2, 32'h1e);
      bus_rd(`FWS_REG_RDATA, 32'h80, 32'he8);
      do_cmd(`FWS_CMD_RESUME, 20'h50000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h2, 32'h16);
      do_cmd(`FWS_CMD_PROG, 20'h00013, pd);
      do_cmd(`FWS_CMD_CERASE, 20'h00000, 8'h00);
      bus_rd(`FWS_REG_STAT, 32'h2, 32'h6);
      do_cmd(`FWS_CMD_READ, 20'h00013, 8'h00);
      bus_rd(`FWS_REG_RDATA, 32'hff, 32'hff);
      repeat (4) @(posedge clk_sys_i);
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
